/* File: rtl/fsg_pkg.sv */
// shared constants for the flash security gate
package fsg_pkg;

  // flash word addresses fetched after reset
  localparam logic [31:0] SEC_CODE_ADDR  = 32'h0010_0000; // protection code word
  localparam logic [31:0] TRIM_WORD_ADDR = 32'h0010_1004; // trim source word
  localparam logic [15:0] PROT_CODE      = 16'h0001;      // value that locks flash
  localparam logic [31:0] ERASED_WORD    = 32'hffff_ffff; // blank flash content
  localparam logic [31:0] INVALID_WORD   = 32'h0000_0000; // answer for locked reads
  localparam int          TRIM_W         = 10;            // trim mirror width

  // boot mode pin codes
  localparam logic [1:0] MODE_USER   = 2'h0; // normal user boot
  localparam logic [1:0] MODE_SERIAL = 2'h1; // serial programming boot

  // access sources
  localparam logic [1:0] SRC_CPU = 2'h0; // internal program
  localparam logic [1:0] SRC_EXT = 2'h1; // serial programming pins
  localparam logic [1:0] SRC_DBG = 2'h2; // debug test port

  // flash commands
  localparam logic [1:0] CMD_READ  = 2'h0; // word read
  localparam logic [1:0] CMD_WRITE = 2'h1; // word program
  localparam logic [1:0] CMD_ERASE = 2'h2; // chip erase
  localparam logic [1:0] CMD_OTHER = 2'h3; // any other command

  // register offsets (byte addresses)
  localparam logic [7:0] REG_TRIM   = 8'h00; // trim mirror, read only
  localparam logic [7:0] REG_STATUS = 8'h04; // gate status, read only
  localparam logic [7:0] REG_OSC    = 8'h08; // source oscillator select

  // status field positions
  localparam int ST_PROT  = 0; // protected flag
  localparam int ST_MODE  = 1; // boot mode, two bits
  localparam int ST_BOOT  = 3; // boot fetch finished
  localparam int ST_ERASE = 4; // chip erase done since reset

  // oscillator select codes and their link rates
  localparam logic [2:0]  OSC_4M   = 3'h0;
  localparam logic [2:0]  OSC_8M   = 3'h1;
  localparam logic [2:0]  OSC_16M  = 3'h2;
  localparam logic [2:0]  OSC_24M  = 3'h3;
  localparam logic [2:0]  OSC_48M  = 3'h4;
  localparam logic [16:0] BAUD_4M  = 17'h0_2580; // 9600 bps
  localparam logic [16:0] BAUD_8M  = 17'h0_4b00; // 19200 bps
  localparam logic [16:0] BAUD_16M = 17'h0_9600; // 38400 bps
  localparam logic [16:0] BAUD_24M = 17'h0_e100; // 57600 bps
  localparam logic [16:0] BAUD_48M = 17'h1_c200; // 115200 bps

  // link rate for an oscillator code; unknown codes give zero (link off)
  function automatic logic [16:0] fsg_baud(input logic [2:0] osc);
    logic [16:0] b;
    b = 17'h0_0000;
    case (osc)
      OSC_4M:  b = BAUD_4M;
      OSC_8M:  b = BAUD_8M;
      OSC_16M: b = BAUD_16M;
      OSC_24M: b = BAUD_24M;
      OSC_48M: b = BAUD_48M;
      default: b = 17'h0_0000;
    endcase
    return b;
  endfunction

endpackage

/* File: rtl/fsg_gate.sv */
// Behaviour
// - load low ten bits of trim word
// - trim mirror readable in both boot modes
// - erased flash clears trim mirror on reset
// - code 0x0001 at security word means protected
// - protection code acts only after reset
// - chip erase then reset lifts protection
// - when protected, external commands except erase refused; reads invalid in serial boot, refused in user boot
// - user boot: internal program fully unrestricted
// - debug port blocked, cannot erase, when protected
// - link baud rate follows oscillator frequency
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module fsg_gate #(
  parameter int REG_AW = 8 // register address width
) (
  input  wire logic              clk,
  input  wire logic              srst,
  // boot mode pins, asynchronous
  input  wire logic [1:0]        boot_mode_pins,
  // register port
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // access requests from cpu, serial path and debug port
  input  wire logic              acc_valid,
  input  wire logic [1:0]        acc_src,
  input  wire logic [1:0]        acc_cmd,
  input  wire logic [31:0]       acc_addr,
  input  wire logic [31:0]       acc_wdata,
  output logic                   acc_done,
  output logic                   acc_refused,
  output logic      [31:0]       acc_rdata,
  output logic                   acc_busy,
  // flash command port
  output logic                   fl_req,
  output logic      [1:0]        fl_cmd,
  output logic      [31:0]       fl_addr,
  output logic      [31:0]       fl_wdata,
  input  wire logic              fl_done,
  input  wire logic [31:0]       fl_rdata,
  // status to the rest of the chip
  output logic                   flash_locked,
  output logic                   boot_done,
  output logic      [1:0]        boot_mode,
  output logic      [16:0]       link_baud
);

  // register decode slices reg_addr[7:0], so the bus must be at least 8 bits wide
  if (REG_AW < 8) begin : g_chk
    $error("fsg_gate: REG_AW must be at least 8");
  end

  // sequencer states
  typedef enum logic [2:0] {
    S_SEC_REQ,
    S_SEC_WAIT,
    S_TRIM_REQ,
    S_TRIM_WAIT,
    S_IDLE,
    S_ACC_WAIT
  } fsg_state_e;

  // all state of the gate
  typedef struct packed {
    logic [1:0]  mode_meta;  // first sync stage
    logic [1:0]  mode_sync;  // second sync stage
    logic [1:0]  boot_mode;  // mode caught as reset ends
    fsg_state_e  st;         // sequencer
    logic        prot;       // protected flag
    logic        erased;     // chip erase done since reset
    logic        boot_done;  // fetch sequence finished
    logic [9:0]  trim;       // trim mirror
    logic [2:0]  osc_sel;    // oscillator select
    logic [16:0] baud;       // link rate
    logic [31:0] rdata;      // register read data
    logic        fl_req;     // flash request pulse
    logic [1:0]  fl_cmd;     // flash command
    logic [31:0] fl_addr;    // flash address
    logic [31:0] fl_wdata;   // flash write data
    logic [1:0]  cur_cmd;    // command in flight
    logic        acc_done;   // access answer pulse
    logic        acc_ref;    // refusal pulse
    logic [31:0] acc_rdata;  // access read data
    logic        busy;       // access in flight
  } fsg_state_s;

  fsg_state_s r_reg;  // registered state
  fsg_state_s r_next; // next state

  // may this source run this command under the current lock
  function automatic logic fsg_allowed(input logic [1:0] src,
                                       input logic [1:0] cmd,
                                       input logic       prot);
    logic ok;
    ok = 1'b1;
    if (prot) begin
      // internal program keeps full access in every mode
      if (src == fsg_pkg::SRC_CPU) begin
        ok = 1'b1;
      // serial path keeps chip erase so a locked part can be recovered
      end else if (src == fsg_pkg::SRC_EXT) begin
        ok = (cmd == fsg_pkg::CMD_ERASE);
      // debug port loses everything, erase included
      end else begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // next-state logic
  always_comb begin
    r_next = r_reg;
    // pulses last one cycle
    r_next.fl_req   = 1'b0;
    r_next.acc_done = 1'b0;
    r_next.acc_ref  = 1'b0;
    // pins pass two flops before use
    r_next.mode_meta = boot_mode_pins;
    r_next.mode_sync = r_reg.mode_meta;

    unique case (r_reg.st)
      // fetch security word; mode pins caught at the same moment
      S_SEC_REQ: begin
        r_next.boot_mode = r_reg.mode_sync;
        r_next.fl_req    = 1'b1;
        r_next.fl_cmd    = fsg_pkg::CMD_READ;
        r_next.fl_addr   = fsg_pkg::SEC_CODE_ADDR;
        r_next.st        = S_SEC_WAIT;
      end
      // lock decided once here and never again until reset
      S_SEC_WAIT: begin
        if (fl_done) begin
          r_next.prot = (fl_rdata[15:0] == fsg_pkg::PROT_CODE);
          r_next.st   = S_TRIM_REQ;
        end
      end
      // fetch trim word
      S_TRIM_REQ: begin
        r_next.fl_req  = 1'b1;
        r_next.fl_cmd  = fsg_pkg::CMD_READ;
        r_next.fl_addr = fsg_pkg::TRIM_WORD_ADDR;
        r_next.st      = S_TRIM_WAIT;
      end
      // blank flash leaves the mirror cleared, old trim is gone
      S_TRIM_WAIT: begin
        if (fl_done) begin
          if (fl_rdata == fsg_pkg::ERASED_WORD) begin
            r_next.trim = '0;
          end else begin
            r_next.trim = fl_rdata[fsg_pkg::TRIM_W-1:0];
          end
          r_next.boot_done = 1'b1;
          r_next.st        = S_IDLE;
        end
      end
      // take one access at a time
      S_IDLE: begin
        if (acc_valid) begin
          // locked serial reads in serial boot answer with junk instead of refusing
          if (r_reg.prot && acc_src == fsg_pkg::SRC_EXT && acc_cmd == fsg_pkg::CMD_READ
              && r_reg.boot_mode == fsg_pkg::MODE_SERIAL) begin
            r_next.acc_done  = 1'b1;
            r_next.acc_rdata = fsg_pkg::INVALID_WORD;
          end else if (fsg_allowed(acc_src, acc_cmd, r_reg.prot)) begin
            r_next.fl_req   = 1'b1;
            r_next.fl_cmd   = acc_cmd;
            r_next.fl_addr  = acc_addr;
            r_next.fl_wdata = acc_wdata;
            r_next.cur_cmd  = acc_cmd;
            r_next.busy     = 1'b1;
            r_next.st       = S_ACC_WAIT;
          end else begin
            r_next.acc_ref = 1'b1;
          end
        end
      end
      // wait for the flash; erase does not unlock until the next reset
      S_ACC_WAIT: begin
        if (fl_done) begin
          r_next.acc_done  = 1'b1;
          r_next.acc_rdata = fl_rdata;
          r_next.busy      = 1'b0;
          r_next.st        = S_IDLE;
          if (r_reg.cur_cmd == fsg_pkg::CMD_ERASE) begin
            r_next.erased = 1'b1;
          end
        end
      end
      // codes 6 and 7 are unused; a flipped state bit restarts the fetch
      default: begin
        r_next.st = S_SEC_REQ;
      end
    endcase

    // register writes; only the oscillator select is writable
    if (reg_wr && reg_addr[7:0] == fsg_pkg::REG_OSC) begin
      r_next.osc_sel = reg_wdata[2:0];
      r_next.baud    = fsg_pkg::fsg_baud(reg_wdata[2:0]);
    end

    // register reads; unmapped offsets read zero
    if (reg_rd) begin
      r_next.rdata = '0;
      if (reg_addr[7:0] == fsg_pkg::REG_TRIM) begin
        r_next.rdata[fsg_pkg::TRIM_W-1:0] = r_reg.trim;
      end else if (reg_addr[7:0] == fsg_pkg::REG_STATUS) begin
        r_next.rdata[fsg_pkg::ST_PROT]       = r_reg.prot;
        r_next.rdata[fsg_pkg::ST_MODE +: 2]  = r_reg.boot_mode;
        r_next.rdata[fsg_pkg::ST_BOOT]       = r_reg.boot_done;
        r_next.rdata[fsg_pkg::ST_ERASE]      = r_reg.erased;
      end else if (reg_addr[7:0] == fsg_pkg::REG_OSC) begin
        r_next.rdata[2:0] = r_reg.osc_sel;
      end
    end
  end

  // state register; reset restarts the fetch sequence
  always_ff @(posedge clk) begin
    if (srst) begin
      r_reg           <= '0;
      r_reg.st        <= S_SEC_REQ;
      r_reg.osc_sel   <= fsg_pkg::OSC_4M;
      r_reg.baud      <= fsg_pkg::BAUD_4M;
      // synchroniser runs through reset so the mode pins are settled at release
      r_reg.mode_meta <= boot_mode_pins;
      r_reg.mode_sync <= r_reg.mode_meta;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state flops
  assign reg_rdata    = r_reg.rdata;
  assign acc_done     = r_reg.acc_done;
  assign acc_refused  = r_reg.acc_ref;
  assign acc_rdata    = r_reg.acc_rdata;
  assign acc_busy     = r_reg.busy;
  assign fl_req       = r_reg.fl_req;
  assign fl_cmd       = r_reg.fl_cmd;
  assign fl_addr      = r_reg.fl_addr;
  assign fl_wdata     = r_reg.fl_wdata;
  assign flash_locked = r_reg.prot;
  assign boot_done    = r_reg.boot_done;
  assign boot_mode    = r_reg.boot_mode;
  assign link_baud    = r_reg.baud;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // trim word lands in the mirror one cycle after the flash answers
  a_trim_load: assert property (
    (r_reg.st == S_TRIM_WAIT && fl_done && fl_rdata != fsg_pkg::ERASED_WORD)
      |=> (r_reg.trim == $past(fl_rdata[9:0]) && boot_done))
    else $error("trim mirror not loaded from flash word");

  // blank trim word clears the mirror
  a_trim_erased: assert property (
    (r_reg.st == S_TRIM_WAIT && fl_done && fl_rdata == fsg_pkg::ERASED_WORD)
      |=> (r_reg.trim == '0))
    else $error("trim mirror not cleared on blank flash");

  // trim read returns the mirror next cycle, any mode
  a_trim_read: assert property (
    (reg_rd && reg_addr[7:0] == fsg_pkg::REG_TRIM)
      |=> (reg_rdata == {22'h00_0000, $past(r_reg.trim)}))
    else $error("trim read data wrong");

  // lock follows the security word exactly
  a_lock_sample: assert property (
    (r_reg.st == S_SEC_WAIT && fl_done)
      |=> (flash_locked == ($past(fl_rdata[15:0]) == fsg_pkg::PROT_CODE)))
    else $error("lock flag disagrees with security word");

  // lock never moves once boot has finished
  a_lock_hold: assert property (
    ($past(boot_done) && boot_done) |-> $stable(flash_locked))
    else $error("lock flag changed without reset");

  // locked serial path: erase goes through, program is refused
  a_ext_erase: assert property (
    (r_reg.st == S_IDLE && acc_valid && acc_src == fsg_pkg::SRC_EXT
     && acc_cmd == fsg_pkg::CMD_ERASE)
      |=> (fl_req && fl_cmd == fsg_pkg::CMD_ERASE && acc_busy))
    else $error("chip erase from serial path not passed");

  a_ext_refuse: assert property (
    (r_reg.st == S_IDLE && acc_valid && flash_locked && acc_src == fsg_pkg::SRC_EXT
     && (acc_cmd == fsg_pkg::CMD_WRITE || acc_cmd == fsg_pkg::CMD_OTHER))
      |=> (acc_refused && !fl_req))
    else $error("locked serial command not refused");

  a_ext_invalid: assert property (
    (r_reg.st == S_IDLE && acc_valid && flash_locked && acc_src == fsg_pkg::SRC_EXT
     && acc_cmd == fsg_pkg::CMD_READ && boot_mode == fsg_pkg::MODE_SERIAL)
      |=> (acc_done && acc_rdata == fsg_pkg::INVALID_WORD && !fl_req))
    else $error("locked serial read not answered with invalid data");

  // internal program always reaches the flash
  a_cpu_pass: assert property (
    (r_reg.st == S_IDLE && acc_valid && acc_src == fsg_pkg::SRC_CPU)
      |=> (fl_req ##1 !fl_req))
    else $error("internal access not forwarded");

  // debug port shut out when locked
  a_dbg_block: assert property (
    (r_reg.st == S_IDLE && acc_valid && flash_locked && acc_src == fsg_pkg::SRC_DBG)
      |=> (acc_refused && !fl_req && !acc_busy))
    else $error("debug access not blocked");

  // link rate follows oscillator select
  a_baud_map: assert property (
    (reg_wr && reg_addr[7:0] == fsg_pkg::REG_OSC)
      |=> (link_baud == fsg_pkg::fsg_baud($past(reg_wdata[2:0]))))
    else $error("link rate does not match oscillator");

  // mode caught from the synchronised pins as the fetch starts
  a_mode_catch: assert property (
    (r_reg.st == S_SEC_REQ) |=> (boot_mode == $past(r_reg.mode_sync)))
    else $error("boot mode not caught from pins");

  // a finished chip erase is remembered until reset
  a_erase_flag: assert property (
    (r_reg.st == S_ACC_WAIT && fl_done && r_reg.cur_cmd == fsg_pkg::CMD_ERASE)
      |=> r_reg.erased)
    else $error("chip erase completion not recorded");

  // one kind of answer per access, never both
  a_answer_one: assert property (
    !(acc_done && acc_refused))
    else $error("access both answered and refused");

  // main scenarios
  c_boot_locked: cover property (boot_done && flash_locked);
  c_ext_erase:   cover property (flash_locked && acc_done && r_reg.erased);
  c_dbg_refused: cover property (flash_locked && acc_refused);
  c_trim_blank:  cover property (boot_done && r_reg.trim == '0);
  c_cpu_locked:  cover property (flash_locked && acc_done && boot_mode == fsg_pkg::MODE_USER);

endmodule

/* File: tb/fsg_flash_model.sv */
`timescale 1ns/1ps
// behavioural flash array on the far side of the gate's command port
module fsg_flash_model (
  input  wire logic        clk,
  input  wire logic [3:0]  lat,      // answer latency in cycles, at least 1
  input  wire logic        fl_req,   // command pulse from the gate
  input  wire logic [1:0]  fl_cmd,   // command code
  input  wire logic [31:0] fl_addr,  // word address
  input  wire logic [31:0] fl_wdata, // program data
  output logic             fl_done,  // one-cycle answer pulse
  output logic [31:0]      fl_rdata  // data beside the answer only
);
  logic [31:0] mem [logic [31:0]]; // sparse content, absent words read erased
  logic [31:0] word;               // data fetched for the pending command

  // one command at a time; a slow latency stresses the gate's wait logic
  // single process so the answer lines have one driver
  initial begin
    fl_done  <= 1'b0;
    fl_rdata <= 32'h5a5a_5a5a;
    forever begin
      @(posedge clk);
      if (fl_req === 1'b1) begin
        word = mem.exists(fl_addr) ? mem[fl_addr] : fsg_pkg::ERASED_WORD;
        if (fl_cmd == fsg_pkg::CMD_WRITE)
          mem[fl_addr] = fl_wdata;
        if (fl_cmd == fsg_pkg::CMD_ERASE)
          mem.delete(); // whole array back to blank
        repeat (lat - 4'h1) @(posedge clk);
        fl_done  <= 1'b1;
        fl_rdata <= word;
        @(posedge clk);
        fl_done  <= 1'b0;
        fl_rdata <= ~word; // stale data must never look valid
      end
    end
  end
endmodule

/* File: tb/fsg_gate_test.sv */
`timescale 1ns/1ps
// self-checking bench for the flash security gate
module fsg_gate_test;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [1:0]  boot_mode_pins = 2'h0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        acc_valid = 1'b0;
  logic [1:0]  acc_src = 2'h0;
  logic [1:0]  acc_cmd = 2'h0;
  logic [31:0] acc_addr = 32'h0;
  logic [31:0] acc_wdata = 32'h0;
  logic        acc_done, acc_refused, acc_busy;
  logic [31:0] acc_rdata;
  logic        fl_req, fl_done;
  logic [1:0]  fl_cmd;
  logic [31:0] fl_addr, fl_wdata, fl_rdata;
  logic        flash_locked, boot_done;
  logic [1:0]  boot_mode;
  logic [16:0] link_baud;
  logic [3:0]  lat = 4'h1;  // flash answer latency
  int          error_cnt = 0;
  int          total_checks = 0;
  logic [16:0] bauds [5] = '{fsg_pkg::BAUD_4M, fsg_pkg::BAUD_8M, fsg_pkg::BAUD_16M,
                             fsg_pkg::BAUD_24M, fsg_pkg::BAUD_48M};

  always #5 clk = ~clk;

  fsg_gate uut (.clk(clk), .srst(srst), .boot_mode_pins(boot_mode_pins),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .acc_valid(acc_valid), .acc_src(acc_src), .acc_cmd(acc_cmd),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_done(acc_done),
    .acc_refused(acc_refused), .acc_rdata(acc_rdata), .acc_busy(acc_busy),
    .fl_req(fl_req), .fl_cmd(fl_cmd), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
    .fl_done(fl_done), .fl_rdata(fl_rdata), .flash_locked(flash_locked),
    .boot_done(boot_done), .boot_mode(boot_mode), .link_baud(link_baud));

  fsg_flash_model flash (.clk(clk), .lat(lat), .fl_req(fl_req), .fl_cmd(fl_cmd),
    .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_done(fl_done), .fl_rdata(fl_rdata));

  // compare and count
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask

  // counts line, verdict, end of run
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // reset with mode pins steady; waits for the boot fetch under a bound
  task automatic do_reset(input logic [1:0] mode);
    @(posedge clk);
    srst <= 1'b1;
    boot_mode_pins <= mode;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 200 && boot_done !== 1'b1; i++)
      @(posedge clk);
    check("boot_done", 32'h1, {31'h0, boot_done});
    check("boot_mode", {30'h0, mode}, {30'h0, boot_mode});
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data looked at only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(what, exp, reg_rdata);
  endtask

  // one access; waits bounded for the done or refused pulse
  task automatic acc(input logic [1:0] s, input logic [1:0] c, input logic [31:0] a,
                     input logic [31:0] wd, input logic ref_exp, input logic [31:0] rd_exp);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_src <= s;
    acc_cmd <= c;
    acc_addr <= a;
    acc_wdata <= wd;
    @(posedge clk);
    acc_valid <= 1'b0;
    for (int i = 0; i < 40 && !seen; i++) begin
      #1;
      if (acc_done === 1'b1 || acc_refused === 1'b1) begin
        seen = 1'b1;
      end else begin
        // no answer yet, so the access must be waiting on the flash
        check("acc_busy", 32'h1, {31'h0, acc_busy});
        @(posedge clk);
      end
    end
    check("answered", 32'h1, {31'h0, seen});
    check("refused", {31'h0, ref_exp}, {31'h0, acc_refused});
    check("busy at answer", 32'h0, {31'h0, acc_busy});
    if (!ref_exp && c == fsg_pkg::CMD_READ)
      check("acc_rdata", rd_exp, acc_rdata);
  endtask

  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    flash.mem[fsg_pkg::SEC_CODE_ADDR] = 32'h0000_0000;
    flash.mem[fsg_pkg::TRIM_WORD_ADDR] = 32'h1234_5abc;
    do_reset(fsg_pkg::MODE_USER);
    reg_read(fsg_pkg::REG_TRIM, 32'h2bc, "trim");
    reg_read(fsg_pkg::REG_STATUS, 32'h8, "status");
    reg_read(8'h0c, 32'h0, "unmapped");
    check("baud reset", {15'h0, fsg_pkg::BAUD_4M}, {15'h0, link_baud});
    acc(fsg_pkg::SRC_EXT, fsg_pkg::CMD_READ, 32'h0010_1004, 0, 0, 32'h1234_5abc);
    // protection code written last by the host
    acc(fsg_pkg::SRC_EXT, fsg_pkg::CMD_WRITE, 32'h0010_0000, 32'h1, 0, 0);
    check("lock before reset", 32'h0, {31'h0, flash_locked});
    acc(fsg_pkg::SRC_DBG, fsg_pkg::CMD_READ, 32'h0010_0000, 0, 0, 32'h1);
    lat = 4'h6;
    // serial programming boot, pin 1 low, pin 0 high
    do_reset(fsg_pkg::MODE_SERIAL);
    reg_read(fsg_pkg::REG_STATUS, 32'hb, "status serial");
    reg_read(fsg_pkg::REG_TRIM, 32'h2bc, "trim serial");
    acc(fsg_pkg::SRC_EXT, fsg_pkg::CMD_READ, 32'h0010_1004, 0, 0, fsg_pkg::INVALID_WORD);
    acc(fsg_pkg::SRC_EXT, fsg_pkg::CMD_WRITE, 32'h0010_0000, 0, 1, 0);
    acc(fsg_pkg::SRC_EXT, fsg_pkg::CMD_OTHER, 32'h0010_0000, 0, 1, 0);
    acc(fsg_pkg::SRC_DBG, fsg_pkg::CMD_READ, 32'h0010_1004, 0, 1, 0);
    acc(fsg_pkg::SRC_DBG, fsg_pkg::CMD_ERASE, 32'h0, 0, 1, 0);
    acc(fsg_pkg::SRC_CPU, fsg_pkg::CMD_READ, 32'h0010_1004, 0, 0, 32'h1234_5abc);
    do_reset(fsg_pkg::MODE_USER);
    reg_read(fsg_pkg::REG_STATUS, 32'h9, "status user");
    acc(fsg_pkg::SRC_CPU, fsg_pkg::CMD_OTHER, 32'h0, 0, 0, 0);
    acc(fsg_pkg::SRC_CPU, fsg_pkg::CMD_READ, 32'h0010_0000, 0, 0, 32'h1);
    acc(fsg_pkg::SRC_EXT, fsg_pkg::CMD_READ, 32'h0010_0000, 0, 1, 0);
    acc(fsg_pkg::SRC_DBG, fsg_pkg::CMD_WRITE, 32'h0010_0000, 0, 1, 0);
    // unlock path: erase over the serial pins, then reset
    do_reset(fsg_pkg::MODE_SERIAL);
    acc(fsg_pkg::SRC_EXT, fsg_pkg::CMD_ERASE, 32'h0, 0, 0, 0);
    reg_read(fsg_pkg::REG_STATUS, 32'h1b, "status erased");
    do_reset(fsg_pkg::MODE_USER);
    reg_read(fsg_pkg::REG_STATUS, 32'h8, "status unlocked");
    reg_read(fsg_pkg::REG_TRIM, 32'h0, "trim erased");
    // every oscillator code, then one outside the table
    for (int k = 0; k < 5; k++) begin
      reg_write(fsg_pkg::REG_OSC, k);
      #1;
      check("link_baud", {15'h0, bauds[k]}, {15'h0, link_baud});
    end
    reg_read(fsg_pkg::REG_OSC, 32'h4, "osc");
    reg_write(fsg_pkg::REG_OSC, 32'h5);
    #1;
    check("baud off", 32'h0, {15'h0, link_baud});
    reg_write(fsg_pkg::REG_TRIM, 32'h3ff);
    reg_read(fsg_pkg::REG_TRIM, 32'h0, "trim ro");
    give_verdict();
  end
endmodule
